// file: rtl/sfc_top.sv
// sfc_top: apb-programmed receive/transmit fifo configuration and interrupts
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module sfc_top #(
	parameter int unsigned FIFO_DEPTH = sfc_pkg::FIFO_DEPTH
) (
	input  wire logic                      mclk,
	input  wire logic                      reset,
	input  wire logic [sfc_pkg::ADDR_W-1:0] paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      uart_nine_bit,
	input  wire logic                      rx_in_valid,
	input  wire logic [7:0]                rx_in_data,
	output logic                           rx_in_ready,
	output logic                           tx_out_valid,
	output logic      [7:0]                tx_out_data,
	input  wire logic                      tx_out_ready,
	output logic                           tx_buf_clear,
	output logic                           irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  ril;
		logic        rx_irq_cond_sel;
		logic [1:0]  til;
		logic        tx_irq_cond_sel;
		logic        fen;
		logic [1:0]  dpx;
		logic [1:0]  sts;
		logic [1:0]  msk;
		logic        rx_hit;
		logic        tx_hit;
		logic        tbuf_clr;
		logic        pop_ok;
		logic [31:0] rdata;
	} sfc_state_t;

	sfc_state_t                  s;
	sfc_state_t                  next_s;
	logic                        en;
	logic                        full;
	logic [sfc_pkg::LVL_W-1:0]   rx_cap;
	logic [sfc_pkg::LVL_W-1:0]   tx_cap;
	logic [sfc_pkg::LVL_W-1:0]   rx_lvl;
	logic [sfc_pkg::LVL_W-1:0]   tx_lvl;
	logic [sfc_pkg::LVL_W-1:0]   rx_trg;
	logic [sfc_pkg::LVL_W-1:0]   tx_trg;
	logic                        rx_cond;
	logic                        tx_cond;
	logic                        wr;
	logic                        rd_acc;
	logic                        mapped;
	logic                        rx_clear;
	logic                        tx_clear;
	logic                        rx_pop;
	logic                        rx_head_ok;
	logic [7:0]                  rx_head;
	logic                        tx_push;

	// ----------------------------------------------------------------
	// sizing and trigger decode
	// ----------------------------------------------------------------
	// nine-bit frames would not fit a byte lane, so the fifos stay shut
	assign en   = s.fen & ~uart_nine_bit;
	assign full = (s.dpx == sfc_pkg::DPX_FULL);
	always_comb
	begin
		rx_cap = sfc_pkg::LVL_ZERO;
		tx_cap = sfc_pkg::LVL_ZERO;
		if (en && full)
		begin
			rx_cap = sfc_pkg::CAP_FULL;
			tx_cap = sfc_pkg::CAP_FULL;
		end
		else if (en && s.dpx == sfc_pkg::DPX_HALF_RX)
			rx_cap = sfc_pkg::CAP_HALF;
		else if (en && s.dpx == sfc_pkg::DPX_HALF_TX)
			tx_cap = sfc_pkg::CAP_HALF;
	end

	assign rx_trg  = sfc_pkg::rx_trig(full, s.ril);
	assign tx_trg  = sfc_pkg::tx_trig(full, s.til);
	assign rx_cond = (rx_cap != sfc_pkg::LVL_ZERO) &&
		(s.rx_irq_cond_sel ? (rx_lvl >= rx_trg) : (rx_lvl == rx_trg));
	assign tx_cond = (tx_cap != sfc_pkg::LVL_ZERO) &&
		(s.tx_irq_cond_sel ? (tx_lvl <= tx_trg) : (tx_lvl == tx_trg));

	// ----------------------------------------------------------------
	// apb slave, zero wait states
	// ----------------------------------------------------------------
	assign pready   = 1'b1;
	assign wr       = psel & penable & pwrite;
	assign rd_acc   = psel & penable & ~pwrite;
	assign pslverr  = psel & penable & ~mapped;
	assign prdata   = s.rdata;
	assign tx_buf_clear = s.tbuf_clr;
	assign irq      = |(s.sts & s.msk);
	assign rx_clear = wr && paddr == sfc_pkg::OFS_RFC &&
		pwdata[sfc_pkg::BIT_FCLR];
	assign tx_clear = wr && paddr == sfc_pkg::OFS_TFC &&
		pwdata[sfc_pkg::BIT_FCLR];
	assign tx_push  = wr && paddr == sfc_pkg::OFS_DATA;
	// pop only what the setup phase already showed, so no byte is lost
	assign rx_pop   = rd_acc && paddr == sfc_pkg::OFS_DATA && s.pop_ok;

	always_comb
	begin
		case (paddr)
			sfc_pkg::OFS_RFC, sfc_pkg::OFS_TFC, sfc_pkg::OFS_SETUP,
			sfc_pkg::OFS_RST, sfc_pkg::OFS_TST, sfc_pkg::OFS_DATA,
			sfc_pkg::OFS_STAT, sfc_pkg::OFS_MASK: mapped = 1'b1;
			default:                              mapped = 1'b0;
		endcase
	end

	always_comb
	begin
		next_s          = s;
		next_s.tbuf_clr = 1'b0;
		next_s.rx_hit   = rx_cond;
		next_s.tx_hit   = tx_cond;
		if (psel && !penable && !pwrite)
		begin
			next_s.rdata  = 32'h0000_0000;
			next_s.pop_ok = 1'b0;
			case (paddr)
				// clear bits are never placed in rdata (tbuf_clr only drives a pulse), so they read as zero
				sfc_pkg::OFS_RFC:
				begin
					next_s.rdata[sfc_pkg::BIT_IS] = s.rx_irq_cond_sel;
					next_s.rdata[1:0] = s.ril;
				end
				sfc_pkg::OFS_TFC:
				begin
					next_s.rdata[sfc_pkg::BIT_IS] = s.tx_irq_cond_sel;
					next_s.rdata[1:0] = s.til;
				end
				sfc_pkg::OFS_SETUP:
				begin
					next_s.rdata[sfc_pkg::BIT_EN] = s.fen;
					next_s.rdata[sfc_pkg::DPX_LSB+:2] = s.dpx;
				end
				sfc_pkg::OFS_RST:  next_s.rdata[2:0] = rx_lvl;
				sfc_pkg::OFS_TST:  next_s.rdata[2:0] = tx_lvl;
				sfc_pkg::OFS_DATA:
				begin
					next_s.rdata[7:0] = rx_head_ok ? rx_head : 8'h00;
					next_s.pop_ok     = rx_head_ok;
				end
				sfc_pkg::OFS_STAT: next_s.rdata[1:0] = s.sts;
				sfc_pkg::OFS_MASK: next_s.rdata[1:0] = s.msk;
				default:           next_s.rdata = 32'h0000_0000;
			endcase
		end
		if (wr)
		begin
			case (paddr)
				sfc_pkg::OFS_RFC:
				begin
					next_s.rx_irq_cond_sel = pwdata[sfc_pkg::BIT_IS];
					next_s.ril  = pwdata[1:0];
				end
				sfc_pkg::OFS_TFC:
				begin
					next_s.tx_irq_cond_sel     = pwdata[sfc_pkg::BIT_IS];
					next_s.til      = pwdata[1:0];
					next_s.tbuf_clr = pwdata[sfc_pkg::BIT_TBCLR];
				end
				sfc_pkg::OFS_SETUP:
				begin
					// order of duplex, enable and clear is up to software
					next_s.fen = pwdata[sfc_pkg::BIT_EN];
					next_s.dpx = pwdata[sfc_pkg::DPX_LSB+:2];
				end
				sfc_pkg::OFS_STAT: next_s.sts = s.sts & ~pwdata[1:0];
				sfc_pkg::OFS_MASK: next_s.msk = pwdata[1:0];
				default:           next_s.msk = s.msk;
			endcase
		end
		// a new entry into the condition wins over a same-cycle clear
		if (rx_cond && !s.rx_hit)
			next_s.sts[sfc_pkg::IRQ_RX] = 1'b1;
		if (tx_cond && !s.tx_hit)
			next_s.sts[sfc_pkg::IRQ_TX] = 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			s <= '0;
		else
			s <= next_s;
	end

	// ----------------------------------------------------------------
	// fifos
	// ----------------------------------------------------------------
	sfc_fifo #(.DEPTH(FIFO_DEPTH), .WIDTH(8)) u_rx_fifo (
		.mclk     (mclk),
		.reset    (reset),
		.clear    (rx_clear),
		.cap      (rx_cap),
		.wr_valid (rx_in_valid),
		.wr_data  (rx_in_data),
		.wr_ready (rx_in_ready),
		.rd_valid (rx_head_ok),
		.rd_data  (rx_head),
		.rd_ready (rx_pop),
		.level    (rx_lvl)
	);

	sfc_fifo #(.DEPTH(FIFO_DEPTH), .WIDTH(8)) u_tx_fifo (
		.mclk     (mclk),
		.reset    (reset),
		.clear    (tx_clear),
		.cap      (tx_cap),
		.wr_valid (tx_push),
		.wr_data  (pwdata[7:0]),
		.wr_ready (),
		.rd_valid (tx_out_valid),
		.rd_data  (tx_out_data),
		.rd_ready (tx_out_ready),
		.level    (tx_lvl)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	AST_RX_CLEAR: assert property (rx_clear |=> rx_lvl == 3'h0)
		else $error("rx fifo not empty after clear");
	AST_RFC_READ: assert property (rd_acc && paddr == sfc_pkg::OFS_RFC
		|-> !prdata[sfc_pkg::BIT_FCLR])
		else $error("rx clear bit read back as one");
	AST_RX_GE: assert property (s.rx_irq_cond_sel && rx_cap != 3'h0 &&
		rx_lvl > rx_trg |-> rx_cond)
		else $error("rx threshold condition missed");
	AST_RX_EQ: assert property (!s.rx_irq_cond_sel && rx_lvl != rx_trg |-> !rx_cond)
		else $error("rx exact condition raised off level");
	AST_TRIG_HALF: assert property (!full && s.ril == 2'h0
		|-> rx_trg == 3'h4)
		else $error("rx half duplex trigger decode wrong");
	AST_TX_SIZE: assert property (en && s.dpx == sfc_pkg::DPX_HALF_TX
		|-> tx_cap == 3'h4 && rx_cap == 3'h0)
		else $error("tx fifo not at full size");
	AST_NINE: assert property (uart_nine_bit |-> !rx_in_ready &&
		tx_cap == 3'h0)
		else $error("fifo in use in nine bit format");
	AST_FULL_CAP: assert property (en && full
		|-> rx_cap == 3'h2 && tx_cap == 3'h2)
		else $error("full duplex sizing wrong");
	AST_TX_CLEAR: assert property (tx_clear |=> tx_lvl == 3'h0 &&
		!tx_out_valid)
		else $error("tx fifo not empty after clear");
	AST_TBUF: assert property (wr && paddr == sfc_pkg::OFS_TFC &&
		pwdata[sfc_pkg::BIT_TBCLR] |=> tx_buf_clear ##1 !tx_buf_clear)
		else $error("transmit buffer clear not a single pulse");
	AST_TX_LE: assert property (s.tx_irq_cond_sel && tx_cap != 3'h0 &&
		tx_lvl < tx_trg |-> tx_cond)
		else $error("tx threshold condition missed");
	// the hit flag must follow at once, or a held condition would re-raise
	AST_RX_IRQ: assert property (rx_cond && !s.rx_hit
		|=> s.sts[sfc_pkg::IRQ_RX] && s.rx_hit)
		else $error("rx interrupt not raised once");

	COV_RX_IRQ: cover property ($rose(s.sts[sfc_pkg::IRQ_RX]) ##1 irq);
	COV_FULL: cover property (en && full && rx_lvl == 3'h2);
	COV_TX_DRAIN: cover property (tx_out_valid && tx_out_ready ##1
		tx_lvl == 3'h0);
	COV_CLR_PUSH: cover property (rx_clear && rx_in_valid);
endmodule // sfc_top
`default_nettype wire

// file: rtl/sfc_pkg.sv
// sfc_pkg: register map, fields and level decode of the serial fifo config
package sfc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W    = 8;
	localparam logic [7:0]  OFS_RFC   = 8'h00;
	localparam logic [7:0]  OFS_TFC   = 8'h04;
	localparam logic [7:0]  OFS_SETUP = 8'h08;
	localparam logic [7:0]  OFS_RST   = 8'h0C;
	localparam logic [7:0]  OFS_TST   = 8'h10;
	localparam logic [7:0]  OFS_DATA  = 8'h14;
	localparam logic [7:0]  OFS_STAT  = 8'h18;
	localparam logic [7:0]  OFS_MASK  = 8'h1C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_FCLR  = 7;
	localparam int BIT_IS    = 6;
	localparam int BIT_TBCLR = 8;
	localparam int BIT_EN    = 0;
	localparam int DPX_LSB   = 1;
	localparam int IRQ_RX    = 0;
	localparam int IRQ_TX    = 1;

	localparam logic [1:0] DPX_HALF_RX = 2'h1;
	localparam logic [1:0] DPX_HALF_TX = 2'h2;
	localparam logic [1:0] DPX_FULL    = 2'h3;

	// ----------------------------------------------------------------
	// fill levels
	// ----------------------------------------------------------------
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned LVL_W      = 3;
	localparam logic [2:0]  LVL_ZERO   = 3'h0;
	localparam logic [2:0]  LVL_ONE    = 3'h1;
	localparam logic [2:0]  LVL_TWO    = 3'h2;
	localparam logic [2:0]  LVL_THREE  = 3'h3;
	localparam logic [2:0]  LVL_FOUR   = 3'h4;
	localparam logic [2:0]  CAP_HALF   = 3'h4;
	localparam logic [2:0]  CAP_FULL   = 3'h2;

	function automatic logic [2:0] rx_trig(input logic full,
		input logic [1:0] sel);
		if (full)
			return sel[0] ? LVL_ONE : LVL_TWO;
		case (sel)
			2'h0:    return LVL_FOUR;
			2'h1:    return LVL_ONE;
			2'h2:    return LVL_TWO;
			default: return LVL_THREE;
		endcase
	endfunction

	function automatic logic [2:0] tx_trig(input logic full,
		input logic [1:0] sel);
		if (full)
			return sel[0] ? LVL_ONE : LVL_ZERO;
		case (sel)
			2'h0:    return LVL_ZERO;
			2'h1:    return LVL_ONE;
			2'h2:    return LVL_TWO;
			default: return LVL_THREE;
		endcase
	endfunction

endpackage

// file: rtl/sfc_fifo.sv
// sfc_fifo: byte fifo with run-time capacity and synchronous clear
`timescale 1ns/100ps
`default_nettype none
module sfc_fifo #(
	parameter int unsigned DEPTH = 4,
	parameter int unsigned WIDTH = 8
) (
	input  wire logic                       mclk,
	input  wire logic                       reset,
	input  wire logic                       clear,
	input  wire logic [$clog2(DEPTH+1)-1:0] cap,
	input  wire logic                       wr_valid,
	input  wire logic [WIDTH-1:0]           wr_data,
	output logic                            wr_ready,
	output logic                            rd_valid,
	output logic [WIDTH-1:0]                rd_data,
	input  wire logic                       rd_ready,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [CW-1:0]               lvl;
	} sfc_fifo_state_t;

	sfc_fifo_state_t s;
	sfc_fifo_state_t next_s;
	logic            push;
	logic            pop;

	assign wr_ready = (s.lvl < cap);
	assign rd_valid = (s.lvl != '0);
	assign rd_data  = s.mem[s.rp];
	assign level    = s.lvl;
	assign push     = wr_valid & wr_ready;
	assign pop      = rd_ready & rd_valid;

	always_comb
	begin
		next_s = s;
		if (clear)
		begin
			// clear beats a same-cycle push or pop
			next_s.wp  = '0;
			next_s.rp  = '0;
			next_s.lvl = '0;
		end
		else
		begin
			if (push)
			begin
				next_s.mem[s.wp] = wr_data;
				next_s.wp = (s.wp == PW'(DEPTH-1)) ? '0 : s.wp + 1'b1;
			end
			if (pop)
				next_s.rp = (s.rp == PW'(DEPTH-1)) ? '0 : s.rp + 1'b1;
			if (push && !pop)
				next_s.lvl = s.lvl + 1'b1;
			else if (pop && !push)
				next_s.lvl = s.lvl - 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			s <= '0;
		else
			s <= next_s;
	end
endmodule // sfc_fifo
`default_nettype wire

// file: tb/sfc_top_test.sv
// sfc_top_test: self-checking bench for the serial fifo configuration block
`timescale 1ns/100ps
`default_nettype none
module sfc_top_test;
	logic        mclk;
	logic        reset;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        uart_nine_bit;
	logic        rx_in_valid;
	logic [7:0]  rx_in_data;
	logic        rx_in_ready;
	logic        tx_out_valid;
	logic [7:0]  tx_out_data;
	logic        tx_out_ready;
	logic        tx_buf_clear;
	logic        irq;
	logic [31:0] rdat;
	logic        rerr;
	int          miscompares;
	int          total_checks;
	int          cycles;
	int          pulses;

	sfc_top u_sfc_top (.mclk, .reset, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .uart_nine_bit, .rx_in_valid,
		.rx_in_data, .rx_in_ready, .tx_out_valid, .tx_out_data,
		.tx_out_ready, .tx_buf_clear, .irq);

	// ----------------------------------------------------------------
	// clock, hang guard, pulse counter
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// a one-cycle pulse must add exactly one here
	always @(posedge mclk)
	begin
		cycles++;
		if (tx_buf_clear === 1'b1)
			pulses++;
		if (cycles == 20000)
		begin
			miscompares++;
			tally_and_finish;
		end
	end

	// ----------------------------------------------------------------
	// compares and bus cycles
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// idle edge at the end keeps psel from being driven twice in one step
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0000_0000);
		chk(rdat, e);
	endtask

	task automatic rx_push(input logic [7:0] d, input logic t);
		rx_in_valid <= 1'b1;
		rx_in_data <= d;
		#1 chk1(rx_in_ready, t);
		@(posedge mclk);
		rx_in_valid <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic tx_pop(input logic [7:0] d);
		tx_out_ready <= 1'b1;
		#1 chk1(tx_out_valid, 1'b1);
		chk({24'h00_0000, tx_out_data}, {24'h00_0000, d});
		@(posedge mclk);
		tx_out_ready <= 1'b0;
		@(posedge mclk);
	endtask

	// duplex and enable in one write, then clear both fifos, then the status
	task automatic cfg(input logic [1:0] dpx);
		wr(sfc_pkg::OFS_SETUP, {29'h0, dpx, 1'b1});
		wr(sfc_pkg::OFS_RFC, 32'h0000_0080);
		wr(sfc_pkg::OFS_TFC, 32'h0000_0080);
		wr(sfc_pkg::OFS_STAT, 32'h0000_0003);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		for (int a = 0; a < 8; a++)
		begin
			rd(8'(a * 4), 32'h0000_0000);
			chk1(rerr, 1'b0);
		end
		wr(8'h20, 32'h0000_ffff);
		chk1(rerr, 1'b1);
		rd(8'h20, 32'h0000_0000);
		chk1(rerr, 1'b1);
		chk1(irq, 1'b0);
	endtask

	// every trigger code, equal mode, filled to capacity
	task automatic t_rx_scan(input logic [1:0] dpx, input int cap);
		logic [2:0] trig;
		cfg(dpx);
		wr(sfc_pkg::OFS_MASK, 32'h0000_0001);
		for (int s = 0; s < 4; s++)
		begin
			trig = (cap == 2) ? ((s % 2) ? 3'h1 : 3'h2)
				: ((s == 0) ? 3'h4 : 3'(s));
			wr(sfc_pkg::OFS_RFC, 32'h0000_0080 | 32'(s));
			rd(sfc_pkg::OFS_RFC, 32'(s));
			rd(sfc_pkg::OFS_RST, 32'h0000_0000);
			wr(sfc_pkg::OFS_STAT, 32'h0000_0001);
			for (int n = 1; n <= cap; n++)
			begin
				rx_push(8'(n), 1'b1);
				rd(sfc_pkg::OFS_RST, 32'(n));
				rd(sfc_pkg::OFS_STAT, 32'(n >= trig));
				chk1(irq, 1'(n >= trig));
			end
			rx_push(8'h5a, 1'b0);
		end
	endtask

	// a pop from 2 to 1 re-enters equal but never left at-or-above
	task automatic t_rx_mode;
		for (int m = 0; m < 2; m++)
		begin
			cfg(sfc_pkg::DPX_HALF_RX);
			wr(sfc_pkg::OFS_MASK, 32'h0000_0000);
			wr(sfc_pkg::OFS_RFC, 32'(m * 64 + 1));
			rx_push(8'h3c, 1'b1);
			rx_push(8'hc3, 1'b1);
			wr(sfc_pkg::OFS_STAT, 32'h0000_0001);
			rd(sfc_pkg::OFS_DATA, 32'h0000_003c);
			rd(sfc_pkg::OFS_STAT, 32'(1 - m));
			chk1(irq, 1'b0);
			wr(sfc_pkg::OFS_MASK, 32'h0000_0001);
			chk1(irq, 1'(1 - m));
			wr(sfc_pkg::OFS_STAT, 32'h0000_0001);
			chk1(irq, 1'b0);
		end
	endtask

	task automatic t_tx(input logic [1:0] dpx, input int cap);
		int p;
		cfg(dpx);
		// trigger code 11: 3 bytes in half duplex, 1 byte in full duplex
		wr(sfc_pkg::OFS_TFC, 32'h0000_0003);
		wr(sfc_pkg::OFS_STAT, 32'h0000_0003);
		for (int n = 0; n <= cap; n++)
			wr(sfc_pkg::OFS_DATA, 32'(n + 16));
		rd(sfc_pkg::OFS_STAT, 32'h0000_0002);
		rd(sfc_pkg::OFS_TST, 32'(cap));
		tx_pop(8'h10);
		rd(sfc_pkg::OFS_TST, 32'(cap - 1));
		p = pulses;
		wr(sfc_pkg::OFS_TFC, 32'h0000_0180);
		rd(sfc_pkg::OFS_TST, 32'h0000_0000);
		chk(32'(pulses - p), 32'h0000_0001);
		rd(sfc_pkg::OFS_TFC, 32'h0000_0000);
		chk1(tx_out_valid, 1'b0);
	endtask

	// from empty, equal-to-one rises on a push, at-or-below stays true
	task automatic t_tx_mode;
		for (int m = 0; m < 2; m++)
		begin
			cfg(sfc_pkg::DPX_HALF_TX);
			wr(sfc_pkg::OFS_TFC, 32'(m * 64 + 1));
			wr(sfc_pkg::OFS_STAT, 32'h0000_0003);
			wr(sfc_pkg::OFS_DATA, 32'h0000_00a5);
			rd(sfc_pkg::OFS_STAT, 32'(2 - 2 * m));
		end
	endtask

	task automatic t_nine;
		cfg(sfc_pkg::DPX_FULL);
		uart_nine_bit <= 1'b1;
		@(posedge mclk);
		rx_push(8'h77, 1'b0);
		wr(sfc_pkg::OFS_DATA, 32'h0000_0066);
		rd(sfc_pkg::OFS_TST, 32'h0000_0000);
		chk1(tx_out_valid, 1'b0);
		uart_nine_bit <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{uart_nine_bit, rx_in_valid, rx_in_data, tx_out_ready} = '0;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		t_reset;
		t_rx_scan(sfc_pkg::DPX_HALF_RX, 4);
		t_rx_scan(sfc_pkg::DPX_FULL, 2);
		t_rx_mode;
		t_tx(sfc_pkg::DPX_HALF_TX, 4);
		t_tx(sfc_pkg::DPX_FULL, 2);
		t_tx_mode;
		t_nine;
		tally_and_finish;
	end
endmodule // sfc_top_test
`default_nettype wire
